// ==== tsw_pkg.sv ====
// Constants, field layouts and carrier types of the descriptor status write-back
// What this block does
// (R1) Clear the active bit when the descriptor's transaction completed.
// (R2) Set stalled on babble, error count reaching zero, or received STALL.
// (R3) A status update that sets stalled also clears active.
// (R4) A STALL answering SETUP also reports the CRC/timeout bit.
// (R5) Set the data buffer fault bit on receive overrun or transmit underrun.
// (R6) On underrun send a wrong CRC; keep active unless errors reached zero. Isochronous words still retire here.
// (R7) On overrun force a timeout so the sender invalidates the transaction.
// (R8) Bus activity past the preset time sets babble and stalled.
// (R9) Babble ends the current frame at once; resume at next frame index.
// (R10) Set NAK seen on a NAK; a NAK answering SETUP also reports CRC/timeout.
// (R11) No response within turnaround limit sets the CRC/timeout bit.
// (R12) A receive CRC error on IN data sets the CRC/timeout bit.
// (R13) Set the bit-stuff fault when received data had over six ones in a row.
// (R14) Flag turnaround timeout when no SOP within 16 to 18 bit times of EOP.
// (R15) Write all status bits in one write-back before the next descriptor.
package tsw_pkg;

  // ****************************************
  // Status word field positions
  // ****************************************
  localparam int ACTIVE_BIT = 23;
  localparam int STALL_BIT = 22;
  localparam int DBF_BIT = 21;
  localparam int BABBLE_BIT = 20;
  localparam int NAK_BIT = 19;
  localparam int CRCTO_BIT = 18;
  localparam int BITSTUFF_BIT = 17;
  localparam int TURNAROUND_TIMEOUT_FLAG_BIT = 16;
  localparam int CTRL_LSB = 24;
  localparam int RSVD_LSB = 11;
  localparam int RSVD_W = 5;
  localparam int ACTLEN_W = 11;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] REG_INT_STATUS = 8'h00;
  localparam logic [7:0] REG_INT_CLEAR = 8'h04;
  localparam logic [7:0] REG_INT_ENABLE = 8'h08;
  localparam logic [7:0] REG_CONTROL = 8'h0c;
  localparam logic [7:0] REG_LAST_STATUS = 8'h10;
  localparam int INT_W = 4;
  localparam logic [INT_W-1:0] INT_RESET = 4'h0;
  localparam int INT_WB_DONE = 0;
  localparam int INT_STALL = 1;
  localparam int INT_BABBLE = 2;
  localparam int INT_ERROR = 3;
  localparam int CTRL_LOW_SPEED = 0;

  // ****************************************
  // Timing: bit times in ps, clock 10 ns
  // ****************************************
  localparam int CLK_PS = 10000;
  localparam int FS_BIT_PS = 83333;
  localparam int LS_BIT_PS = 666667;
  localparam int FS_BIT_CYC = FS_BIT_PS / CLK_PS;
  localparam int LS_BIT_CYC = LS_BIT_PS / CLK_PS;
  localparam int TA_MIN_BITS = 16;
  localparam int TA_MAX_BITS = 18;
  localparam int TA_LIMIT_BITS = (TA_MIN_BITS + TA_MAX_BITS) / 2;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef enum logic [1:0] {HS_NONE = 2'h0, HS_ACK = 2'h1, HS_NAK = 2'h2,
    HS_STALL = 2'h3} tsw_hs_t;

  typedef struct packed {
    logic start;        // Transaction begins, pulse
    logic done;         // Transaction over, pulse
    logic is_setup;
    logic is_in;
    logic is_iso;
    tsw_hs_t hs;        // Handshake seen, valid with done
    logic crc_err;
    logic stuff_err;
    logic overrun;      // Live level while receiving
    logic underrun;     // Live level while transmitting
    logic err_zero;     // Error count reached zero, valid with done
    logic await_resp;   // Waiting for device packet after our EOP
    logic [ACTLEN_W-1:0] actlen;
    logic [31:0] old_word;
  } tsw_txn_t;

endpackage

// ==== tsw_status_writeback.sv ====
// Descriptor status write-back of a full/low-speed USB host controller
`timescale 1ns/10ps
module tsw_status_writeback
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire tsw_pkg::tsw_txn_t txn,
  input wire logic eof_window,
  input wire logic usb_dp,
  input wire logic usb_dm,
  output logic wb_valid,
  input wire logic wb_ready,
  output logic [31:0] wb_word,
  output logic td_busy,
  output logic bad_crc_insert,
  output logic force_timeout,
  output logic frame_abort,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);

  // ****************************************
  // Pin synchronisers, three stages
  // ****************************************
  logic [2:0] dp_sync_reg, dp_sync_next;
  logic [2:0] dm_sync_reg, dm_sync_next;
  logic dp_reg, dp_next;
  logic dm_reg, dm_next;

  // Third stage only updates the accepted level once stages two and three agree
  always_comb
  begin
    dp_sync_next = {dp_sync_reg[1:0], usb_dp};
    dm_sync_next = {dm_sync_reg[1:0], usb_dm};
    dp_next = (dp_sync_reg[1] == dp_sync_reg[2]) ? dp_sync_reg[2] : dp_reg;
    dm_next = (dm_sync_reg[1] == dm_sync_reg[2]) ? dm_sync_reg[2] : dm_reg;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      // Start at full-speed idle J so no false SE0-to-J edge follows reset
      dp_sync_reg <= 3'h7;
      dm_sync_reg <= 3'h0;
      dp_reg <= 1'b1;
      dm_reg <= 1'b0;
    end
    else
    begin
      dp_sync_reg <= dp_sync_next;
      dm_sync_reg <= dm_sync_next;
      dp_reg <= dp_next;
      dm_reg <= dm_next;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  logic [tsw_pkg::INT_W-1:0] int_stat_reg, int_stat_next;
  logic [tsw_pkg::INT_W-1:0] int_en_reg, int_en_next;
  logic [tsw_pkg::INT_W-1:0] int_evt;
  logic ctrl_ls_reg, ctrl_ls_next;
  logic [31:0] last_word_reg, last_word_next;
  logic [31:0] rdata_reg, rdata_next;

  // Set wins over clear so an event in the clearing cycle is kept
  always_comb
  begin
    int_stat_next = int_stat_reg;
    int_en_next = int_en_reg;
    ctrl_ls_next = ctrl_ls_reg;
    rdata_next = 32'h0;
    if (reg_wr && reg_addr == tsw_pkg::REG_INT_CLEAR)
      int_stat_next = int_stat_reg & ~reg_wdata[tsw_pkg::INT_W-1:0];
    int_stat_next = int_stat_next | int_evt;
    if (reg_wr && reg_addr == tsw_pkg::REG_INT_ENABLE)
      int_en_next = reg_wdata[tsw_pkg::INT_W-1:0];
    if (reg_wr && reg_addr == tsw_pkg::REG_CONTROL)
      ctrl_ls_next = reg_wdata[tsw_pkg::CTRL_LOW_SPEED];
    if (reg_rd)
    begin
      case (reg_addr)
        tsw_pkg::REG_INT_STATUS:
          rdata_next = {28'h0, int_stat_reg};
        tsw_pkg::REG_INT_ENABLE:
          rdata_next = {28'h0, int_en_reg};
        tsw_pkg::REG_CONTROL:
          rdata_next = {31'h0, ctrl_ls_reg};
        tsw_pkg::REG_LAST_STATUS:
          rdata_next = last_word_reg;
        default:
          rdata_next = 32'h0; // Unmapped and write-only read as zero
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      int_stat_reg <= tsw_pkg::INT_RESET;
      int_en_reg <= tsw_pkg::INT_RESET;
      ctrl_ls_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end
    else
    begin
      int_stat_reg <= int_stat_next;
      int_en_reg <= int_en_next;
      ctrl_ls_reg <= ctrl_ls_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq = |(int_stat_reg & int_en_reg);

  // ****************************************
  // Bit-time divider and line decode
  // ****************************************
  localparam logic [6:0] FS_RELOAD = 7'(tsw_pkg::FS_BIT_CYC - 1);
  localparam logic [6:0] LS_RELOAD = 7'(tsw_pkg::LS_BIT_CYC - 1);
  logic [6:0] div_reg, div_next;
  logic bit_tick;
  logic line_j, line_k, line_se0;

  // Low speed swaps the meaning of J and K on the data pair
  assign line_se0 = ~dp_reg & ~dm_reg;
  assign line_j = ctrl_ls_reg ? (~dp_reg & dm_reg) : (dp_reg & ~dm_reg);
  assign line_k = ctrl_ls_reg ? (dp_reg & ~dm_reg) : (~dp_reg & dm_reg);
  assign bit_tick = (div_reg == 7'h0);

  // Integer division; the full-speed bit runs slightly fast, near the low end of 16..18
  always_comb
  begin
    if (bit_tick)
      div_next = ctrl_ls_reg ? LS_RELOAD : FS_RELOAD;
    else
      div_next = div_reg - 7'h1;
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      div_reg <= 7'h0;
    else
      div_reg <= div_next;
  end

  // ****************************************
  // Turnaround timer and babble watch
  // ****************************************
  localparam logic [4:0] TA_LIMIT = 5'(tsw_pkg::TA_LIMIT_BITS);
  logic se0_d_reg, se0_d_next;
  logic ta_run_reg, ta_run_next;
  logic [4:0] ta_cnt_reg, ta_cnt_next;
  logic ta_expire;

  assign ta_expire = ta_run_reg && bit_tick && ta_cnt_reg == TA_LIMIT - 5'h1;

  // Timer starts at the SE0-to-idle edge of our EOP and stops on a K state
  always_comb
  begin
    se0_d_next = line_se0;
    ta_run_next = ta_run_reg;
    ta_cnt_next = ta_cnt_reg;
    if (txn.await_resp && se0_d_reg && line_j && !ta_run_reg)
    begin
      ta_run_next = 1'b1;
      ta_cnt_next = 5'h0;
    end
    else if (ta_run_reg)
    begin
      if (line_k || !txn.await_resp || ta_expire)
        ta_run_next = 1'b0; // (R14)
      else if (bit_tick)
        ta_cnt_next = ta_cnt_reg + 5'h1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      se0_d_reg <= 1'b0;
      ta_run_reg <= 1'b0;
      ta_cnt_reg <= 5'h0;
    end
    else
    begin
      se0_d_reg <= se0_d_next;
      ta_run_reg <= ta_run_next;
      ta_cnt_reg <= ta_cnt_next;
    end
  end

  // ****************************************
  // Per-transaction event capture
  // ****************************************
  logic turnaround_timeout_flag_seen_reg, turnaround_timeout_flag_seen_next;
  logic babble_seen_reg, babble_seen_next;
  logic over_seen_reg, over_seen_next;
  logic under_seen_reg, under_seen_next;
  logic babble_evt;
  logic abort_reg, abort_next;
  logic crc_reg, crc_next;
  logic fto_reg, fto_next;

  // Any non-idle line inside the end-of-frame window counts as babble
  assign babble_evt = eof_window && !line_j; // (R8)

  // A start clears the capture, but an event in the same cycle still sets it
  always_comb
  begin
    turnaround_timeout_flag_seen_next = (turnaround_timeout_flag_seen_reg && !txn.start) || ta_expire; // (R14)
    babble_seen_next = (babble_seen_reg && !txn.start) || babble_evt;
    over_seen_next = (over_seen_reg && !txn.start) || txn.overrun;
    under_seen_next = (under_seen_reg && !txn.start) || txn.underrun;
    abort_next = babble_evt && !babble_seen_reg; // (R9)
    crc_next = txn.underrun || (under_seen_reg && !txn.start); // (R6)
    fto_next = txn.overrun || (over_seen_reg && !txn.start); // (R7)
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      turnaround_timeout_flag_seen_reg <= 1'b0;
      babble_seen_reg <= 1'b0;
      over_seen_reg <= 1'b0;
      under_seen_reg <= 1'b0;
      abort_reg <= 1'b0;
      crc_reg <= 1'b0;
      fto_reg <= 1'b0;
    end
    else
    begin
      turnaround_timeout_flag_seen_reg <= turnaround_timeout_flag_seen_next;
      babble_seen_reg <= babble_seen_next;
      over_seen_reg <= over_seen_next;
      under_seen_reg <= under_seen_next;
      abort_reg <= abort_next;
      crc_reg <= crc_next;
      fto_reg <= fto_next;
    end
  end

  assign frame_abort = abort_reg;
  assign bad_crc_insert = crc_reg;
  assign force_timeout = fto_reg;

  // ****************************************
  // Status word build and write-back
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_WRITE = 2'b10} tsw_state_t;
  tsw_state_t state_reg, state_next;
  logic [31:0] word_reg, word_next;
  logic stall_b, dbf_b, babble_b, nak_b, crcto_b, active_b, timeout_b;
  logic [31:0] word_new;

  // Decode the outcome of the finished transaction into descriptor bits
  always_comb
  begin
    babble_b = babble_seen_reg || babble_evt; // (R8)
    dbf_b = over_seen_reg || under_seen_reg; // (R5)
    nak_b = txn.hs == tsw_pkg::HS_NAK; // (R10)
    timeout_b = turnaround_timeout_flag_seen_reg || ta_expire ||
      (txn.hs == tsw_pkg::HS_NONE && !txn.is_iso && !dbf_b);
    stall_b = babble_b || txn.err_zero || txn.hs == tsw_pkg::HS_STALL; // (R2)
    crcto_b = timeout_b // (R11)
      || (txn.is_in && txn.crc_err) // (R12)
      || (txn.is_setup && txn.hs == tsw_pkg::HS_STALL) // (R4)
      || (txn.is_setup && nak_b); // (R10)
    active_b = txn.old_word[tsw_pkg::ACTIVE_BIT];
    if (txn.hs == tsw_pkg::HS_ACK || txn.is_iso)
      active_b = 1'b0; // (R1)
    // Isochronous words always retire, even after an underrun
    if (under_seen_reg && !txn.err_zero && !txn.is_iso)
      active_b = txn.old_word[tsw_pkg::ACTIVE_BIT]; // (R6)
    if (stall_b)
      active_b = 1'b0; // (R3)
    word_new = txn.old_word;
    word_new[tsw_pkg::ACTIVE_BIT] = active_b;
    word_new[tsw_pkg::STALL_BIT] = stall_b;
    word_new[tsw_pkg::DBF_BIT] = dbf_b;
    word_new[tsw_pkg::BABBLE_BIT] = babble_b;
    word_new[tsw_pkg::NAK_BIT] = nak_b;
    word_new[tsw_pkg::CRCTO_BIT] = crcto_b;
    word_new[tsw_pkg::BITSTUFF_BIT] = txn.stuff_err; // (R13)
    word_new[tsw_pkg::TURNAROUND_TIMEOUT_FLAG_BIT] = turnaround_timeout_flag_seen_reg || ta_expire; // (R14)
    word_new[tsw_pkg::RSVD_LSB +: tsw_pkg::RSVD_W] = 5'h0;
    word_new[tsw_pkg::ACTLEN_W-1:0] = txn.actlen;
  end

  // One write of the whole word; td_busy holds off the next descriptor
  always_comb
  begin
    state_next = state_reg;
    word_next = word_reg;
    last_word_next = last_word_reg;
    int_evt = 4'h0;
    case (state_reg)
      ST_IDLE:
        if (txn.done)
        begin
          word_next = word_new; // (R15)
          state_next = ST_WRITE;
        end
      ST_WRITE:
        if (wb_ready)
        begin
          last_word_next = word_reg;
          int_evt[tsw_pkg::INT_WB_DONE] = 1'b1;
          int_evt[tsw_pkg::INT_STALL] = word_reg[tsw_pkg::STALL_BIT];
          int_evt[tsw_pkg::INT_BABBLE] = word_reg[tsw_pkg::BABBLE_BIT];
          int_evt[tsw_pkg::INT_ERROR] = word_reg[tsw_pkg::CRCTO_BIT] |
            word_reg[tsw_pkg::DBF_BIT] | word_reg[tsw_pkg::BITSTUFF_BIT];
          state_next = ST_IDLE;
        end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_IDLE;
      word_reg <= 32'h0;
      last_word_reg <= 32'h0;
    end
    else
    begin
      state_reg <= state_next;
      word_reg <= word_next;
      last_word_reg <= last_word_next;
    end
  end

  assign wb_valid = (state_reg == ST_WRITE); // (R15)
  assign wb_word = word_reg;
  assign td_busy = (state_reg == ST_WRITE);

endmodule // tsw_status_writeback

// ==== tsw_status_writeback_assertions.sv ====
// Concurrent checks on the status write-back ports
`timescale 1ns/10ps
module tsw_wb_checker
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire tsw_pkg::tsw_txn_t txn,
  input wire logic wb_valid,
  input wire logic wb_ready,
  input wire logic [31:0] wb_word,
  input wire logic td_busy,
  input wire logic bad_crc_insert
);
  // ****************************************
  // Sequences and properties
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Outcome taken while idle; a done during a pending word is dropped
  sequence taken_s;
    txn.done && !wb_valid;
  endsequence
  // Word offered, memory not ready yet
  sequence wait_s;
    wb_valid && !wb_ready;
  endsequence
  wb_raise_a: assert property (taken_s |=> wb_valid && td_busy)
    else $error("no status word after done");
  wb_hold_a: assert property (wait_s |=> wb_valid && $stable(wb_word))
    else $error("status word changed before taken");
  stall_inactive_a: assert property (wb_valid && wb_word[22] |->
    !wb_word[23]) else $error("stalled word still active");
  babble_stall_a: assert property (wb_valid && wb_word[20] |->
    wb_word[22]) else $error("babble without stall");
  errcnt_stall_a: assert property (taken_s ##0 txn.err_zero |=>
    wb_word[22]) else $error("spent error count not stalled");
  setup_stall_a: assert property (taken_s ##0 (txn.is_setup &&
    txn.hs == tsw_pkg::HS_STALL) |=> wb_word[22] && wb_word[18])
    else $error("setup stall lacks timeout flag");
  iso_inactive_a: assert property (taken_s ##0 txn.is_iso |=>
    !wb_word[23]) else $error("iso word left active");
  underrun_crc_a: assert property (txn.underrun && !txn.start |=>
    bad_crc_insert) else $error("no bad crc on underrun");
endmodule // tsw_wb_checker

bind tsw_status_writeback tsw_wb_checker tsw_wb_checker_inst
(
  .clock, .sys_rst, .txn, .wb_valid, .wb_ready, .wb_word, .td_busy,
  .bad_crc_insert
);

// ==== tsw_usb_device.sv ====
// Behavioural full- or low-speed device endpoint on the bus pins
`timescale 1ns/10ps
module tsw_usb_device
(
  input wire logic clock,
  output logic usb_dp,
  output logic usb_dm
);
  // ****************************************
  // Line states: 0 SE0, 1 J, 2 K
  // ****************************************
  // Low speed swaps J and K and stretches the bit; set by the bench
  logic ls = 1'b0;
  // Idle is J, where the plus-line pull-up leaves it between packets
  initial
  begin
    usb_dp = 1'b1;
    usb_dm = 1'b0;
  end
  // Hold one line state for whole bit times, changed just after an edge
  task automatic put(input int st, input int bits);
    @(posedge clock);
    usb_dp <= ls ? st == 2 : st == 1;
    usb_dm <= ls ? st == 1 : st == 2;
    repeat (bits * (ls ? tsw_pkg::LS_BIT_CYC : tsw_pkg::FS_BIT_CYC) - 1)
      @(posedge clock);
  endtask
endmodule // tsw_usb_device

// ==== test_tsw_status_writeback.sv ====
// Self-checking bench for the descriptor status write-back
`timescale 1ns/10ps
module test_tsw_status_writeback;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  tsw_pkg::tsw_txn_t txn = '0;
  logic eof_window = 1'b0;
  logic wb_ready = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic usb_dp, usb_dm, wb_valid, td_busy, bad_crc_insert, force_timeout;
  logic frame_abort, irq, cur_ov, cur_un;
  logic [31:0] wb_word, reg_rdata, last;
  int fail_count = 0;
  int cmp_count = 0;
  int ab_cnt = 0;
  int seed = 45702;
  // ****************************************
  // Clock, design and device model
  // ****************************************
  always #5 clock = ~clock;
  tsw_status_writeback tsw_status_writeback_inst
  (
    .clock, .sys_rst, .txn, .eof_window, .usb_dp, .usb_dm, .wb_valid,
    .wb_ready, .wb_word, .td_busy, .bad_crc_insert, .force_timeout,
    .frame_abort, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq
  );
  tsw_usb_device tsw_usb_device_inst (.clock, .usb_dp, .usb_dm);
  // Count abort pulses; a long babble must still give only one
  always @(posedge clock)
    if (frame_abort === 1'b1)
      ab_cnt <= ab_cnt + 1;
  // Compare and count
  task automatic check(input logic [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One-cycle register strobes, changed just after an edge
  task automatic reg_w(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_r(input logic [7:0] a, input logic [31:0] e,
      input string what);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, e, what);
  endtask
  // Random outcome; a buffer fault never meets an ACK, whose priority is open
  function automatic tsw_pkg::tsw_txn_t rnd_txn(input logic dbf);
    tsw_pkg::tsw_txn_t t;
    logic [31:0] r;
    r = $random(seed);
    t = '0;
    t.is_setup = r[0];
    t.is_in = !r[0] & r[1];
    t.is_iso = t.is_in & r[2];
    t.hs = tsw_pkg::tsw_hs_t'(dbf ? {r[3], 1'b0} : r[4:3]);
    t.crc_err = t.is_in & r[5];
    t.stuff_err = t.is_in & r[6];
    t.err_zero = r[7];
    t.actlen = r[18:8];
    t.old_word = {r[31:24], 1'b1, 23'h0};
    return t;
  endfunction
  // Status word expected from the outcome and the bus events
  function automatic logic [31:0] exp_word(input tsw_pkg::tsw_txn_t t,
      input logic dbf, bab, bt);
    logic st, ct, ac;
    st = bab | t.err_zero | (t.hs == tsw_pkg::HS_STALL);
    ct = t.crc_err | (t.is_setup & t.hs[1]) | bt
      | (t.hs == tsw_pkg::HS_NONE & !t.is_iso & !dbf);
    ac = (t.hs == tsw_pkg::HS_ACK | t.is_iso | st) ? 1'b0 : t.old_word[23];
    return {t.old_word[31:24], ac, st, dbf, bab, t.hs == tsw_pkg::HS_NAK, ct,
      t.stuff_err, bt, 5'h0, t.actlen};
  endfunction
  // Start pulse, then live buffer fault levels
  task automatic begin_txn(input logic ov, un);
    cur_ov = ov;
    cur_un = un;
    @(posedge clock);
    txn.start <= 1'b1;
    @(posedge clock);
    txn.start <= 1'b0;
    txn.overrun <= ov;
    txn.underrun <= un;
  endtask
  // Done pulse, word check, memory stalls a random time before taking it
  task automatic end_txn(input tsw_pkg::tsw_txn_t t, input logic bab, bt);
    int n;
    @(posedge clock);
    #1 check(bad_crc_insert, cur_un, "bad crc level");
    check(force_timeout, cur_ov, "forced timeout");
    t.done = 1'b1;
    t.overrun = cur_ov;
    t.underrun = cur_un;
    @(posedge clock);
    txn <= t;
    @(posedge clock);
    txn <= '0;
    n = 0;
    #1;
    while (wb_valid !== 1'b1 && n < 20)
    begin
      @(posedge clock);
      #1 n++;
    end
    last = exp_word(t, cur_ov | cur_un, bab, bt);
    check(wb_valid, 1'b1, "word offered");
    check(td_busy, 1'b1, "descriptor held");
    check(wb_word, last, "status word");
    repeat (2'($random(seed))) @(posedge clock);
    @(posedge clock);
    wb_ready <= 1'b1;
    @(posedge clock);
    wb_ready <= 1'b0;
    #1 check(wb_valid, 1'b0, "word released");
    check(td_busy, 1'b0, "descriptor freed");
  endtask
  // Verdict, reached by the tests or the watchdog
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog at about four times the expected run
  initial
  begin
    #100000;
    fail_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    print_verdict();
  end
  // Main sequence
  initial
  begin
    tsw_pkg::tsw_txn_t t;
    logic [31:0] r;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    for (int a = 0; a < 6; a++)
      reg_r(8'(a * 4), 32'h0, "reset or unmapped");
    reg_w(tsw_pkg::REG_INT_STATUS, 32'hf);
    reg_w(tsw_pkg::REG_CONTROL, 32'h1);
    reg_r(tsw_pkg::REG_CONTROL, 32'h1, "control");
    reg_w(tsw_pkg::REG_CONTROL, 32'h0);
    reg_r(tsw_pkg::REG_INT_STATUS, 32'h0, "read-only status");
    $display("test registers done");
    for (int i = 0; i < 26; i++)
    begin
      r = $random(seed);
      if (i >= 24)
        r[1:0] = 2'h3; // Last two force a buffer fault
      t = rnd_txn(r[0] & r[1]);
      // Corner cases: one receive overrun, one transmit underrun
      if (i == 24)
      begin
        t.is_setup = 1'b0;
        t.is_in = 1'b1;
      end
      if (i == 25)
      begin
        t.is_in = 1'b0;
        t.is_iso = 1'b0;
        t.crc_err = 1'b0;
        t.stuff_err = 1'b0;
      end
      begin_txn(r[0] & r[1] & t.is_in, r[0] & r[1] & !t.is_in);
      repeat (r[4:2]) @(posedge clock);
      end_txn(t, 1'b0, 1'b0);
    end
    #1 check(irq, 1'b0, "masked irq");
    reg_w(tsw_pkg::REG_INT_ENABLE, 32'hf);
    #1 check(irq, 1'b1, "enabled irq");
    reg_r(tsw_pkg::REG_LAST_STATUS, last, "last word");
    reg_w(tsw_pkg::REG_INT_CLEAR, 32'hf);
    reg_r(tsw_pkg::REG_INT_STATUS, 32'h0, "cleared status");
    #1 check(irq, 1'b0, "cleared irq");
    $display("test random outcomes done");
    t = rnd_txn(1'b0);
    t.is_iso = 1'b0;
    t.hs = tsw_pkg::HS_NONE;
    begin_txn(1'b0, 1'b0);
    eof_window <= 1'b1;
    tsw_usb_device_inst.put(2, 6);
    tsw_usb_device_inst.put(1, 1);
    eof_window <= 1'b0;
    end_txn(t, 1'b1, 1'b0);
    check(ab_cnt, 1, "abort pulses");
    reg_r(tsw_pkg::REG_INT_STATUS, 32'hf, "babble status");
    reg_w(tsw_pkg::REG_INT_CLEAR, 32'hf);
    $display("test babble done");
    // Full speed silent, full speed answered, then low speed silent
    for (int k = 0; k < 3; k++)
    begin
      t.hs = (k == 1) ? tsw_pkg::HS_ACK : tsw_pkg::HS_NONE;
      if (k == 2)
      begin
        reg_w(tsw_pkg::REG_CONTROL, 32'h1);
        tsw_usb_device_inst.ls = 1'b1;
      end
      begin_txn(1'b0, 1'b0);
      txn.await_resp <= 1'b1;
      tsw_usb_device_inst.put(0, 2);
      tsw_usb_device_inst.put(1, (k == 1) ? 4 : 20);
      if (k == 1)
        tsw_usb_device_inst.put(2, 1);
      tsw_usb_device_inst.put(1, 1);
      end_txn(t, 1'b0, k != 1);
    end
    $display("test turnaround done");
    print_verdict();
  end
endmodule // test_tsw_status_writeback
